// [common/word_loader_pkg.sv]
/*
 Shared constants and carrier types for the coefficient and control word loader.
 Assumes one master clock; both load ports are synchronous to it.
*/
package word_loader_pkg;
   // Word and field geometry
   localparam int WORD_W = 12;
   localparam int CLASS_HI = 11;
   localparam int CLASS_LO = 9;
   localparam int LOC_W = 9;
   localparam int CTRL_IDX_W = 4;
   localparam int COEF_WORDS = 8;
   localparam int ROUND_WORDS = 4;
   localparam int LIMIT_WORDS = 2;
   localparam int SINGLE_WORDS = 1;
   localparam int ROUND_W = 32;
   localparam int ROUND_BYTE_W = 8;
   localparam int LIMIT_W = 24;
   localparam int SEL_W = 5;
   localparam int CFG_COUNT = 6;
   localparam int CFG_IDX_W = 3;
   localparam int CNT_W = 4;

   // Target classes carried in the top address bits
   typedef enum logic [2:0] {
      CLS_COEF = 3'h0,
      CLS_CFG = 3'h1,
      CLS_HSEL = 3'h2,
      CLS_VSEL = 3'h3,
      CLS_HRND = 3'h4,
      CLS_VRND = 3'h5,
      CLS_HLIM = 3'h6,
      CLS_VLIM = 3'h7
   } target_class_t;

   // Port sequencer states: idle, then data once the address word is taken
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_DATA = 2'h1
   } port_state_t;

   // One port's committed write to a control register
   typedef struct packed {
      logic valid;
      target_class_t cls;
      logic [LOC_W-1:0] loc;
      logic [ROUND_W-1:0] value;
   } ctrl_write_t;

   // One port's committed coefficient set
   typedef struct packed {
      logic valid;
      logic [LOC_W-1:0] loc;
      logic [COEF_WORDS*WORD_W-1:0] coefs;
   } coef_write_t;
endpackage

// [verilog/load_port_seq.sv]
/*
 One word-serial load port: takes an address word then the data words of
 its class, and emits one commit pulse once the whole group is in.
 Assumes strobe, hold and word are synchronous to clk.
*/
`timescale 1ns/1ps
module load_port_seq (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Load pins
   input wire logic load_strobe_n,
   input wire logic load_hold,
   input wire logic [word_loader_pkg::WORD_W-1:0] load_word,
   // Commits
   output word_loader_pkg::ctrl_write_t ctrl_wr,
   output word_loader_pkg::coef_write_t coef_wr
);
   typedef struct packed {
      word_loader_pkg::port_state_t st;
      word_loader_pkg::target_class_t cls;
      logic [word_loader_pkg::LOC_W-1:0] loc;
      logic [word_loader_pkg::CNT_W-1:0] cnt;
      logic [word_loader_pkg::COEF_WORDS*word_loader_pkg::WORD_W-1:0] shift;
      word_loader_pkg::ctrl_write_t cw;
      word_loader_pkg::coef_write_t kw;
   } seq_state_t;

   seq_state_t cur_ff;
   seq_state_t nxt_ff;

   // Words expected after the address for each class
   function automatic logic [word_loader_pkg::CNT_W-1:0] words_for(
      input word_loader_pkg::target_class_t c);
      case (c)
         word_loader_pkg::CLS_COEF: words_for = 4'(word_loader_pkg::COEF_WORDS);
         word_loader_pkg::CLS_HRND,
         word_loader_pkg::CLS_VRND: words_for = 4'(word_loader_pkg::ROUND_WORDS);
         word_loader_pkg::CLS_HLIM,
         word_loader_pkg::CLS_VLIM: words_for = 4'(word_loader_pkg::LIMIT_WORDS);
         default: words_for = 4'(word_loader_pkg::SINGLE_WORDS);
      endcase
   endfunction

   // Sequencer; hold freezes everything but the commit pulses, including the strobe view
   always_comb begin
      logic [word_loader_pkg::CNT_W-1:0] last;
      logic [word_loader_pkg::COEF_WORDS*word_loader_pkg::WORD_W-1:0] sh;
      last = words_for(cur_ff.cls);
      sh = {load_word, cur_ff.shift[word_loader_pkg::COEF_WORDS*word_loader_pkg::WORD_W-1
                                    :word_loader_pkg::WORD_W]};
      nxt_ff = cur_ff;
      nxt_ff.cw.valid = 1'b0;
      nxt_ff.kw.valid = 1'b0;
      if (!load_hold) begin
         if (load_strobe_n) begin
            nxt_ff.st = word_loader_pkg::ST_IDLE;
         end else if (cur_ff.st == word_loader_pkg::ST_IDLE) begin
            // First word with strobe low is the address
            nxt_ff.st = word_loader_pkg::ST_DATA;
            nxt_ff.cls = word_loader_pkg::target_class_t'(
               load_word[word_loader_pkg::CLASS_HI:word_loader_pkg::CLASS_LO]);
            nxt_ff.loc = load_word[word_loader_pkg::LOC_W-1:0];
            nxt_ff.cnt = '0;
         end else begin
            nxt_ff.shift = sh;
            nxt_ff.cnt = cur_ff.cnt + 4'h1;
            if (cur_ff.cnt + 4'h1 == last) begin
               nxt_ff.st = word_loader_pkg::ST_IDLE;
               if (cur_ff.cls == word_loader_pkg::CLS_COEF) begin
                  nxt_ff.kw.valid = 1'b1;
                  nxt_ff.kw.loc = cur_ff.loc;
                  nxt_ff.kw.coefs = sh;                      // bank 0 in low word
               end else begin
                  nxt_ff.cw.valid = 1'b1;
                  nxt_ff.cw.cls = cur_ff.cls;
                  nxt_ff.cw.loc = cur_ff.loc;
                  nxt_ff.cw.value = '0;
                  case (cur_ff.cls)
                     word_loader_pkg::CLS_HRND,
                     word_loader_pkg::CLS_VRND: begin
                        // Low byte of each word, first word least significant
                        for (int i = 0; i < word_loader_pkg::ROUND_WORDS; i++) begin
                           nxt_ff.cw.value[i*8 +: 8] =
                              sh[(word_loader_pkg::COEF_WORDS-word_loader_pkg::ROUND_WORDS+i)
                                 *word_loader_pkg::WORD_W +: 8];
                        end
                     end
                     word_loader_pkg::CLS_HLIM,
                     word_loader_pkg::CLS_VLIM: begin
                        // Lower limit first, upper second
                        nxt_ff.cw.value[23:0] = sh[8*word_loader_pkg::WORD_W-1
                                                   :6*word_loader_pkg::WORD_W];
                     end
                     default: begin
                        nxt_ff.cw.value[11:0] = load_word;
                     end
                  endcase
               end
            end
         end
      end
   end

   // Register the state copy
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   assign ctrl_wr = cur_ff.cw;
   assign coef_wr = cur_ff.kw;
endmodule

// [verilog/coef_and_control_word_loader.sv]
/*
 Coefficient and control word loader: two independent word-serial load ports
 fill horizontal and vertical coefficient banks and the shared configuration,
 select, round and limit registers. Assumes a host drives all load pins
 synchronously to clk; contents are exposed as flat buses for the datapath.
*/
// Overview of operation
// - A coefficient set loads in nine cycles: address then banks 0..7.
// - Round loads take five cycles, limit loads take three.
// - Nothing is written until all data words of the group arrive.
// - Round registers update only after the fourth data word.
// - The word after a group's last data word is a new address.
// - Horizontal banks load only via horizontal port; vertical via vertical.
// - Configuration and control registers load through either port.
// - Both ports run independently and concurrently.
// - Same-cycle control writes from both ports: vertical wins.
// - A port losing arbitration keeps sequencing as if it wrote.
// - Round words assemble least significant byte first.
// - Limit: first word is lower limit, second upper limit.
// - Address word comes with the strobe fall or right after a group; bits 11..9 class.
// - Data words expected: 8 coefficient, 1 select/config, 4 round, 2 limit.
// - A high hold input freezes the port and ignores the word bus.
// - Limit registers keep lower in bits 11..0, upper in 23..12.
`timescale 1ns/1ps
module coef_and_control_word_loader #(
   parameter int SETS = 256,
   parameter int CTRL_REGS = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Horizontal load port
   input wire logic horiz_load_strobe_n,
   input wire logic horiz_load_hold,
   input wire logic [word_loader_pkg::WORD_W-1:0] horiz_load_word,
   // Vertical load port
   input wire logic vert_load_strobe_n,
   input wire logic vert_load_hold,
   input wire logic [word_loader_pkg::WORD_W-1:0] vert_load_word,
   // Coefficient read ports for the filters
   input wire logic [7:0] horiz_coef_set,
   input wire logic [7:0] vert_coef_set,
   output logic [word_loader_pkg::COEF_WORDS*word_loader_pkg::WORD_W-1:0] horiz_coefs,
   output logic [word_loader_pkg::COEF_WORDS*word_loader_pkg::WORD_W-1:0] vert_coefs,
   // Register contents
   output logic [word_loader_pkg::CFG_COUNT*word_loader_pkg::WORD_W-1:0] cfg_regs,
   output logic [CTRL_REGS*word_loader_pkg::SEL_W-1:0] horiz_sel_regs,
   output logic [CTRL_REGS*word_loader_pkg::SEL_W-1:0] vert_sel_regs,
   output logic [CTRL_REGS*word_loader_pkg::ROUND_W-1:0] horiz_round_regs,
   output logic [CTRL_REGS*word_loader_pkg::ROUND_W-1:0] vert_round_regs,
   output logic [CTRL_REGS*word_loader_pkg::LIMIT_W-1:0] horiz_limit_regs,
   output logic [CTRL_REGS*word_loader_pkg::LIMIT_W-1:0] vert_limit_regs
);
   localparam int CW = word_loader_pkg::COEF_WORDS*word_loader_pkg::WORD_W;

   // Elaboration check: read addresses and indices are fixed widths
   if (SETS != 256 || CTRL_REGS != 16) begin : g_bad_param
      $error("loader supports only 256 sets and 16 control registers");
   end

   word_loader_pkg::ctrl_write_t h_cw;
   word_loader_pkg::ctrl_write_t v_cw;
   word_loader_pkg::coef_write_t h_kw;
   word_loader_pkg::coef_write_t v_kw;
   word_loader_pkg::ctrl_write_t win;

   // Two independent sequencers
   load_port_seq u_horiz (
      .clk(clk),
      .sys_rst(sys_rst),
      .load_strobe_n(horiz_load_strobe_n),
      .load_hold(horiz_load_hold),
      .load_word(horiz_load_word),
      .ctrl_wr(h_cw),
      .coef_wr(h_kw)
   );
   load_port_seq u_vert (
      .clk(clk),
      .sys_rst(sys_rst),
      .load_strobe_n(vert_load_strobe_n),
      .load_hold(vert_load_hold),
      .load_word(vert_load_word),
      .ctrl_wr(v_cw),
      .coef_wr(v_kw)
   );

   // Vertical port takes the shared registers on a clash; the loser is
   // simply not written and its sequencer never learns of it
   assign win = v_cw.valid ? v_cw : h_cw;

   // Bank memories, each written only by its own port as a whole set
   logic [CW-1:0] horiz_bank_mem [SETS];
   logic [CW-1:0] vert_bank_mem [SETS];

   // Memories carry no reset; contents are undefined until loaded
   always_ff @(posedge clk) begin
      if (h_kw.valid) begin
         horiz_bank_mem[h_kw.loc[7:0]] <= h_kw.coefs;
      end
      if (v_kw.valid) begin
         vert_bank_mem[v_kw.loc[7:0]] <= v_kw.coefs;
      end
   end

   // Registered read so filter taps see flip-flop outputs
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         horiz_coefs <= '0;
         vert_coefs <= '0;
      end else begin
         horiz_coefs <= horiz_bank_mem[horiz_coef_set];
         vert_coefs <= vert_bank_mem[vert_coef_set];
      end
   end

   // Control register file, one generate entry per index
   for (genvar i = 0; i < CTRL_REGS; i++) begin : g_ctrl
      logic hit;
      assign hit = win.valid && (win.loc[3:0] == 4'(i));
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            horiz_sel_regs[i*5 +: 5] <= '0;
            vert_sel_regs[i*5 +: 5] <= '0;
            horiz_round_regs[i*32 +: 32] <= '0;
            vert_round_regs[i*32 +: 32] <= '0;
            horiz_limit_regs[i*24 +: 24] <= '0;
            vert_limit_regs[i*24 +: 24] <= '0;
         end else if (hit) begin
            case (win.cls)
               word_loader_pkg::CLS_HSEL: horiz_sel_regs[i*5 +: 5] <= win.value[4:0];
               word_loader_pkg::CLS_VSEL: vert_sel_regs[i*5 +: 5] <= win.value[4:0];
               word_loader_pkg::CLS_HRND: horiz_round_regs[i*32 +: 32] <= win.value;
               word_loader_pkg::CLS_VRND: vert_round_regs[i*32 +: 32] <= win.value;
               word_loader_pkg::CLS_HLIM: horiz_limit_regs[i*24 +: 24] <= win.value[23:0];
               word_loader_pkg::CLS_VLIM: vert_limit_regs[i*24 +: 24] <= win.value[23:0];
               default: begin
               end
            endcase
         end
      end
   end

   // Configuration registers; out-of-range locations are dropped
   for (genvar j = 0; j < word_loader_pkg::CFG_COUNT; j++) begin : g_cfg
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            cfg_regs[j*12 +: 12] <= '0;
         end else if (win.valid && win.cls == word_loader_pkg::CLS_CFG
                      && win.loc == 9'(j)) begin
            cfg_regs[j*12 +: 12] <= win.value[11:0];
         end
      end
   end
endmodule

// [tb/host_port_model.sv]
/*
 Host model for one word-serial load port: drives strobe, hold and word.
 Assumes the load port samples on the rising edge of clk.
*/
`timescale 1ns/1ps
module host_port_model (
   // Clock
   input wire logic clk,
   // Load pins
   output logic strobe_n,
   output logic hold,
   output logic [word_loader_pkg::WORD_W-1:0] word
);
   // Idle at time zero with the strobe high
   initial begin
      strobe_n = 1'b1;
      hold = 1'b0;
      word = 12'h000;
   end

   // One burst, strobe low throughout; one stall cycle before word pause_at
   task automatic send(input logic [11:0] w[$], input int pause_at);
      for (int i = 0; i < w.size(); i++) begin
         @(posedge clk);
         if (i == pause_at) begin
            hold <= 1'b1;
            word <= ~w[i];
            @(posedge clk);
         end
         hold <= 1'b0;
         strobe_n <= 1'b0;
         word <= w[i];
      end
      @(posedge clk);
      strobe_n <= 1'b1;
      word <= ~word; // Released bus shows the inverse, not the last word
   endtask
endmodule

// [tb/coef_and_control_word_loader_checker.sv]
/*
 Port-level assertions for the word loader, bound into the top module.
 Assumes commits land two edges after the last data word is taken.
*/
`timescale 1ns/1ps
module coef_and_control_word_loader_checker #(
   parameter int SETS = 256,
   parameter int CTRL_REGS = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Load ports
   input wire logic horiz_load_strobe_n,
   input wire logic horiz_load_hold,
   input wire logic [word_loader_pkg::WORD_W-1:0] horiz_load_word,
   input wire logic vert_load_strobe_n,
   input wire logic vert_load_hold,
   input wire logic [word_loader_pkg::WORD_W-1:0] vert_load_word,
   // Contents
   input wire logic [7:0] horiz_coef_set,
   input wire logic [7:0] vert_coef_set,
   input wire logic [word_loader_pkg::COEF_WORDS*word_loader_pkg::WORD_W-1:0] horiz_coefs,
   input wire logic [word_loader_pkg::COEF_WORDS*word_loader_pkg::WORD_W-1:0] vert_coefs,
   input wire logic [word_loader_pkg::CFG_COUNT*word_loader_pkg::WORD_W-1:0] cfg_regs,
   input wire logic [CTRL_REGS*word_loader_pkg::SEL_W-1:0] horiz_sel_regs,
   input wire logic [CTRL_REGS*word_loader_pkg::SEL_W-1:0] vert_sel_regs,
   input wire logic [CTRL_REGS*word_loader_pkg::ROUND_W-1:0] horiz_round_regs,
   input wire logic [CTRL_REGS*word_loader_pkg::ROUND_W-1:0] vert_round_regs,
   input wire logic [CTRL_REGS*word_loader_pkg::LIMIT_W-1:0] horiz_limit_regs,
   input wire logic [CTRL_REGS*word_loader_pkg::LIMIT_W-1:0] vert_limit_regs
);
   logic both_idle, any_take;
   // A port neither strobed nor free to take a word can commit nothing new
   assign both_idle = (horiz_load_strobe_n | horiz_load_hold)
                      & (vert_load_strobe_n | vert_load_hold);
   assign any_take = ~(horiz_load_strobe_n | horiz_load_hold)
                     | ~(vert_load_strobe_n | vert_load_hold);

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   idle_cfg_stable_a: assert property (both_idle [*4] |=> $stable(cfg_regs))
      else $error("config changed while both ports idle");
   idle_round_stable_a: assert property (
      both_idle [*4] |=> $stable({horiz_round_regs, vert_round_regs}))
      else $error("round changed while both ports idle");
   idle_limit_stable_a: assert property (
      both_idle [*4] |=> $stable({horiz_limit_regs, vert_limit_regs}))
      else $error("limit changed while both ports idle");
   idle_sel_stable_a: assert property (
      both_idle [*4] |=> $stable({horiz_sel_regs, vert_sel_regs}))
      else $error("select changed while both ports idle");
   cfg_change_cause_a: assert property ($changed(cfg_regs) |-> $past(any_take, 2))
      else $error("config changed without a word two edges before");
   round_change_cause_a: assert property (
      $changed({horiz_round_regs, vert_round_regs}) |-> $past(any_take, 2))
      else $error("round changed without a word two edges before");
   limit_change_cause_a: assert property (
      $changed({horiz_limit_regs, vert_limit_regs}) |-> $past(any_take, 2))
      else $error("limit changed without a word two edges before");
   sel_change_cause_a: assert property (
      $changed({horiz_sel_regs, vert_sel_regs}) |-> $past(any_take, 2))
      else $error("select changed without a word two edges before");

   // Main scenarios reached
   cover property ($changed(horiz_round_regs));
   cover property ($changed(vert_limit_regs));
   cover property (!horiz_load_strobe_n && !vert_load_strobe_n);
endmodule

bind coef_and_control_word_loader coef_and_control_word_loader_checker #(
   .SETS(SETS), .CTRL_REGS(CTRL_REGS)) chk_u (
   .clk(clk), .sys_rst(sys_rst), .horiz_load_strobe_n(horiz_load_strobe_n),
   .horiz_load_hold(horiz_load_hold), .horiz_load_word(horiz_load_word),
   .vert_load_strobe_n(vert_load_strobe_n), .vert_load_hold(vert_load_hold),
   .vert_load_word(vert_load_word), .horiz_coef_set(horiz_coef_set),
   .vert_coef_set(vert_coef_set), .horiz_coefs(horiz_coefs), .vert_coefs(vert_coefs),
   .cfg_regs(cfg_regs), .horiz_sel_regs(horiz_sel_regs), .vert_sel_regs(vert_sel_regs),
   .horiz_round_regs(horiz_round_regs), .vert_round_regs(vert_round_regs),
   .horiz_limit_regs(horiz_limit_regs), .vert_limit_regs(vert_limit_regs));

// [tb/tb_coef_and_control_word_loader.sv]
/*
 Self-checking bench for the word loader with one host model per port.
 Assumes register outputs settle within four edges of the last word.
*/
`timescale 1ns/1ps
module tb_coef_and_control_word_loader;
   localparam int WW = word_loader_pkg::WORD_W;
   localparam int RW = word_loader_pkg::ROUND_W;
   localparam int LW = word_loader_pkg::LIMIT_W;
   localparam int SW = word_loader_pkg::SEL_W;
   logic clk, sys_rst, hs_n, hh, vs_n, vh;
   logic [WW-1:0] hw, vw;
   logic [7:0] hset, vset;
   logic [8*WW-1:0] hc, vc;
   logic [6*WW-1:0] cfg;
   logic [16*SW-1:0] hsel, vsel;
   logic [16*RW-1:0] hrnd, vrnd;
   logic [16*LW-1:0] hlim, vlim;
   logic [WW-1:0] hx[$], vx[$], ix[$], hq[$], vq[$];
   int fails = 0;
   int cmp_count = 0;
   int cycles = 0;

   coef_and_control_word_loader dut_u (.clk(clk), .sys_rst(sys_rst),
      .horiz_load_strobe_n(hs_n), .horiz_load_hold(hh), .horiz_load_word(hw),
      .vert_load_strobe_n(vs_n), .vert_load_hold(vh), .vert_load_word(vw),
      .horiz_coef_set(hset), .vert_coef_set(vset), .horiz_coefs(hc), .vert_coefs(vc),
      .cfg_regs(cfg), .horiz_sel_regs(hsel), .vert_sel_regs(vsel), .horiz_round_regs(hrnd),
      .vert_round_regs(vrnd), .horiz_limit_regs(hlim), .vert_limit_regs(vlim));
   host_port_model host_h (.clk(clk), .strobe_n(hs_n), .hold(hh), .word(hw));
   host_port_model host_v (.clk(clk), .strobe_n(vs_n), .hold(vh), .word(vw));

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Commit plus registered read need a few edges
   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask

   task automatic test_coef();
      fork
         host_h.send({12'h00a, hx}, -1);
         host_v.send({12'h00a, vx}, 3);
      join
      settle();
      for (int k = 0; k < 8; k++) begin
         check("horiz coef", 32'(hc[k*WW +: WW]), 32'(hx[k]));
         check("vert coef", 32'(vc[k*WW +: WW]), 32'(vx[k]));
      end
      // Two sets back to back in one burst, then set 10 read again
      host_h.send({12'h00c, vx, 12'h00a, ix}, 5);
      settle();
      for (int k = 0; k < 8; k++) begin
         check("horiz coef second set", 32'(hc[k*WW +: WW]), 32'(ix[k]));
         check("vert coef kept", 32'(vc[k*WW +: WW]), 32'(vx[k]));
      end
      @(posedge clk);
      hset <= 8'h0c;
      settle();
      check("horiz coef set 12", 32'(hc[7*WW +: WW]), 32'(vx[7]));
      $display("test coef done");
   endtask

   task automatic test_round();
      hq = '{12'h80c, 12'h0a2, 12'h0f4, 12'h083};
      host_h.send(hq, -1);
      settle();
      check("round partial", hrnd[12*RW +: RW], 32'h0);
      hq.push_back(12'h076);
      host_h.send(hq, 2);
      settle();
      check("horiz round", hrnd[12*RW +: RW], 32'h7683f4a2);
      check("vert round", vrnd[12*RW +: RW], 32'h0);
      host_h.send('{12'hc0a, 12'h123, 12'h456}, 1);
      settle();
      check("horiz limit", 32'(hlim[10*LW +: LW]), 32'h456123);
      $display("test round done");
   endtask

   task automatic test_chain();
      vq = '{12'h204, 12'h003, 12'h402, 12'h00f, 12'he07, 12'h390, 12'h743, 12'h60f, 12'h01b,
             12'ha00, 12'h011, 12'h022, 12'h033, 12'h044};
      host_v.send(vq, -1);
      settle();
      check("config 4", 32'(cfg[4*WW +: WW]), 32'h003);
      check("horiz select 2", 32'(hsel[2*SW +: SW]), 32'h0f);
      check("vert limit 7", 32'(vlim[7*LW +: LW]), 32'h743390);
      check("vert select 15", 32'(vsel[15*SW +: SW]), 32'h1b);
      check("vert round 0", vrnd[0 +: RW], 32'h44332211);
      $display("test chain done");
   endtask

   task automatic test_arb();
      fork
         host_h.send('{12'h201, 12'h0aa, 12'h203, 12'h0bb, 12'h205, 12'h0cc}, -1);
         host_v.send('{12'h201, 12'h055, 12'h40e, 12'h011}, -1);
      join
      settle();
      check("config 1", 32'(cfg[1*WW +: WW]), 32'h055);
      check("config 3 dropped", 32'(cfg[3*WW +: WW]), 32'h000);
      check("horiz select 14", 32'(hsel[14*SW +: SW]), 32'h11);
      check("config 5", 32'(cfg[5*WW +: WW]), 32'h0cc);
      check("config 4 kept", 32'(cfg[4*WW +: WW]), 32'h003);
      $display("test arbitration done");
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Hang guard; the whole run needs just over a hundred cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fails++;
         $display("mismatch run length expected finish seen hang");
         tally_and_finish();
      end
   end

   initial begin
      sys_rst = 1'b1;
      hset = 8'h0a;
      vset = 8'h0a;
      hx = '{12'h210, 12'h543, 12'hc76, 12'h9e3, 12'h701, 12'h832, 12'hf20, 12'h143};
      for (int k = 0; k < 8; k++) begin
         vx.push_back(12'h0f0 + 12'(k));
         ix.push_back(~hx[k]);
      end
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      test_coef();
      test_round();
      test_chain();
      test_arb();
      tally_and_finish();
   end
endmodule
